// ---- hw/toc_unit.sv ----
// two-channel output compare unit of a 16-bit timer, apb register slave
// ********************************************************************
// How it works
// - each channel compares full 16-bit count with its compare value
// - match flag sets one timer tick after the tick that saw equality
// - set flag with its irq enable high raises that channel's interrupt
// - flag clears on interrupt service or software writing one
// - channel a compare value is offered to the counter as top
// - compare value buffered in pwm modes, written directly otherwise
// - buffer moves into active compare value only at top or bottom
// - cpu compare accesses reach buffer when buffered, active otherwise
// - compare value changed only by cpu; high byte read directly
// - high write loads shared latch; low write copies latch into top byte
// - force strobe in non-pwm modes acts like a match, no flag
// - counter write blocks every match at the following timer tick
// - output action bits unbuffered, govern the very next match
// - output state registers clear to zero on reset
// - nonzero action puts output state on pin; direction stays with port
// - action zero leaves output state unchanged at a match
// - action bits do not touch input capture in any way
// - output state survives changes of waveform mode
// - output derived from match, bottom and count direction per mode and action
// - mode zero is normal, non-pwm, compare values unbuffered
// - modes four and twelve clear on match, both non-pwm
// ********************************************************************
//
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/100ps
`default_nettype none

module toc_unit (
   input  wire logic                 core_clk_in,
   input  wire logic                 rst_n_in,
   input  wire toc_pkg::toc_apb_req_t apb_req_in,
   output logic                      apb_pready_out,
   output logic                      apb_pslverr_out,
   output logic [31:0]               apb_prdata_out,
   input  wire toc_pkg::toc_timer_t  timer_in,
   input  wire logic [1:0]           irq_ack_in,
   input  wire logic [1:0]           port_data_in,
   input  wire logic [1:0]           port_dir_in,
   output logic [1:0]                pin_out,
   output logic [1:0]                pin_oe_out,
   output logic [1:0]                irq_out,
   output logic [1:0]                match_out,
   output logic [15:0]               top_value_a_out
);
   import toc_pkg::*;

   // ****************************************************************
   // mode helpers
   // ****************************************************************

   // normal and both clear-on-match codes are non-pwm; the reserved
   // code is treated as non-pwm too so it never buffers
   function automatic logic mode_is_pwm(input logic [3:0] m);
      mode_is_pwm = !(m == TOC_MODE_NORMAL || m == TOC_MODE_CLR_A ||
                      m == TOC_MODE_CLR_CAP || m == TOC_MODE_RESERVED);
   endfunction : mode_is_pwm

   // single-slope modes: 5,6,7,14,15
   function automatic logic mode_is_fast(input logic [3:0] m);
      mode_is_fast = (m == 4'h5) || (m == 4'h6) || (m == 4'h7) ||
                     (m == 4'he) || (m == 4'hf);
   endfunction : mode_is_fast

   // dual-slope modes that update at top do so at the turning point
   // phase and frequency correct and single-slope modes reload at bottom, the rest at top
   function automatic logic mode_load_bottom(input logic [3:0] m);
      mode_load_bottom = (m == 4'h8) || (m == 4'h9) || mode_is_fast(m);
   endfunction : mode_load_bottom

   // non-pwm action on a match or a forced match
   function automatic logic act_step(input logic [1:0] a,
                                     input logic       cur);
      case (a)
         TOC_ACT_TOGGLE: act_step = ~cur;
         TOC_ACT_CLEAR:  act_step = 1'b0;
         TOC_ACT_SET:    act_step = 1'b1;
         default:        act_step = cur;
      endcase
   endfunction : act_step

   // ****************************************************************
   // state
   // ****************************************************************
   toc_state_t s_q;
   toc_state_t s_d;

   logic       acc_phase;
   logic       bus_do;
   logic       wr_do;
   logic [7:0] wbyte;
   logic [1:0] eq;
   logic       pwm;
   logic       load_pt;

   // one wait state per access is the price of registered bus outputs;
   // a master that holds psel and penable as the protocol asks sees it
   // bus phases: the slave answers on the second access cycle
   assign acc_phase = apb_req_in.psel && apb_req_in.penable;
   assign bus_do    = acc_phase && s_q.pready;
   assign wr_do     = bus_do && apb_req_in.pwrite;
   assign wbyte     = apb_req_in.pwdata[7:0];
   assign pwm       = mode_is_pwm(s_q.mode);

   // loading only at an extreme of the count keeps every pwm period
   // whole; a value written mid-period waits for the next update point
   // reload point for the double buffer
   assign load_pt = timer_in.tick &&
                    (mode_load_bottom(s_q.mode) ? timer_in.bottom
                                                : timer_in.top);

   // equality works on the live count in every clock, not only on
   // ticks, so the match output is one clock late but never skips
   // continuous equality per channel
   always_comb begin
      for (int c = 0; c < 2; c++) begin
         eq[c] = (timer_in.count == s_q.cmp[c]);
      end
   end

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      logic [1:0] clr;
      logic [1:0] hit;
      logic [1:0] force_bits;
      s_d        = s_q;
      clr        = 2'b00;
      force_bits = 2'b00;
      hit        = 2'b00;

      s_d.match = eq;

      // equality seen at one tick becomes a hit at the next, which
      // gives the flag its one timer clock of delay behind the match
      // compare engine, qualified by the timer tick
      if (timer_in.tick) begin
         hit      = s_q.pend;
         s_d.pend = s_q.block ? 2'b00 : eq;
         s_d.block = 1'b0;
      end
      // the block stays armed until a tick consumes it, so a load made
      // while the timer is stopped still hides the first match; a load
      // equal to a compare value therefore loses that match for good
      // a counter write arms the block even on a tick edge
      if (timer_in.count_wr) begin
         s_d.block = 1'b1;
      end

      // output actions are read live from the control register, so a
      // new action governs the very next match, forced or real
      // waveform generation per channel
      for (int c = 0; c < 2; c++) begin
         if (!pwm) begin
            if (hit[c]) begin
               // action read live, no buffering
               s_d.out_state[c] = act_step(s_q.act[c],
                                           s_q.out_state[c]);
            end
         end else if (s_q.act[c] == TOC_ACT_CLEAR ||
                      s_q.act[c] == TOC_ACT_SET) begin
            // inverting mode is the set code
            if (mode_is_fast(s_q.mode)) begin
               if (hit[c]) begin
                  s_d.out_state[c] = s_q.act[c][0];
               end else if (timer_in.tick && timer_in.bottom) begin
                  s_d.out_state[c] = ~s_q.act[c][0];
               end
            end else if (hit[c]) begin
               // dual slope: direction picks the level
               s_d.out_state[c] = s_q.act[c][0] ^ timer_in.down;
            end
         end
         // pwm with action none or toggle leaves state alone
      end

      // a cpu write in the same cycle as the reload lands in the buffer
      // afterwards and waits for the following update point
      // double buffer reload at the update point
      if (pwm && load_pt) begin
         s_d.cmp = s_q.buf_;
      end

      // ------------------------------------------------------------
      // register writes, taken on the edge where pready is sampled
      // ------------------------------------------------------------
      // high writes only fill the shared latch; the low write moves all
      // sixteen bits at once so the comparator never sees a half value
      if (wr_do) begin
         case (apb_req_in.paddr)
            TOC_OFF_CTRL_A: begin
               // mode change keeps the output states
               s_d.mode          = wbyte[TOC_POS_MODE +: 4];
               s_d.act[TOC_CH_A] = wbyte[TOC_POS_ACT_A +: 2];
               s_d.act[TOC_CH_B] = wbyte[TOC_POS_ACT_B +: 2];
            end
            TOC_OFF_CTRL_C: begin
               force_bits = wbyte[1:0];
            end
            TOC_OFF_FLAG: begin
               clr = wbyte[1:0];
            end
            TOC_OFF_MASK: begin
               s_d.irq_en = wbyte[1:0];
            end
            TOC_OFF_CMP_A_HI,
            TOC_OFF_CMP_B_HI: begin
               s_d.temp = wbyte;
            end
            TOC_OFF_CMP_A_LO: begin
               if (pwm) begin
                  s_d.buf_[TOC_CH_A] = {s_q.temp, wbyte};
               end else begin
                  s_d.cmp[TOC_CH_A]  = {s_q.temp, wbyte};
                  s_d.buf_[TOC_CH_A] = {s_q.temp, wbyte};
               end
            end
            TOC_OFF_CMP_B_LO: begin
               if (pwm) begin
                  s_d.buf_[TOC_CH_B] = {s_q.temp, wbyte};
               end else begin
                  s_d.cmp[TOC_CH_B]  = {s_q.temp, wbyte};
                  s_d.buf_[TOC_CH_B] = {s_q.temp, wbyte};
               end
            end
            default: begin
            end
         endcase
      end

      // a force in the same cycle as a real match acts on the state
      // that the match has already produced
      // forced match: non-pwm only, no flag, counter untouched
      if (!pwm) begin
         for (int c = 0; c < 2; c++) begin
            if (force_bits[c]) begin
               s_d.out_state[c] = act_step(s_q.act[c],
                                           s_d.out_state[c]);
            end
         end
      end

      // a clear racing a new hit must not lose the event, hence the
      // set term is or-ed in after the clear mask
      // flags: hardware set wins over any clear
      clr = clr | irq_ack_in;
      s_d.flag = (s_q.flag & ~clr) | hit;
      s_d.irq  = s_d.flag & s_d.irq_en;

      // the port keeps the direction, so a pin set as input never shows
      // the output state even while the override is selected
      // pin override; direction always from the port
      for (int c = 0; c < 2; c++) begin
         s_d.pin[c] = (s_q.act[c] != TOC_ACT_NONE) ? s_d.out_state[c]
                                                   : port_data_in[c];
      end
      s_d.pin_oe = port_dir_in;
      // action bits feed nothing on the capture side

      // ------------------------------------------------------------
      // apb answer, registered so outputs come from flip-flops
      // ------------------------------------------------------------
      // the !pready term limits pready to one cycle at a time, so it never
      // stands two cycles running; an access still held is answered again every second cycle
      s_d.pready  = acc_phase && !s_q.pready;
      s_d.pslverr = 1'b0;
      s_d.prdata  = 32'h0000_0000;
      if (acc_phase && !s_q.pready) begin
         case (apb_req_in.paddr)
            TOC_OFF_CTRL_A: begin
               s_d.prdata[7:0] = {s_q.act[TOC_CH_A], s_q.act[TOC_CH_B],
                                  s_q.mode};
            end
            TOC_OFF_CTRL_C: begin
               s_d.prdata[7:0] = 8'h00;  // strobes read as zero
            end
            TOC_OFF_FLAG: begin
               s_d.prdata[1:0] = s_q.flag;
            end
            TOC_OFF_MASK: begin
               s_d.prdata[1:0] = s_q.irq_en;
            end
            TOC_OFF_CMP_A_LO: begin
               s_d.prdata[7:0] = pwm ? s_q.buf_[TOC_CH_A][7:0]
                                     : s_q.cmp[TOC_CH_A][7:0];
            end
            TOC_OFF_CMP_A_HI: begin
               // high byte read directly, never via the latch
               s_d.prdata[7:0] = pwm ? s_q.buf_[TOC_CH_A][15:8]
                                     : s_q.cmp[TOC_CH_A][15:8];
            end
            TOC_OFF_CMP_B_LO: begin
               s_d.prdata[7:0] = pwm ? s_q.buf_[TOC_CH_B][7:0]
                                     : s_q.cmp[TOC_CH_B][7:0];
            end
            TOC_OFF_CMP_B_HI: begin
               s_d.prdata[7:0] = pwm ? s_q.buf_[TOC_CH_B][15:8]
                                     : s_q.cmp[TOC_CH_B][15:8];
            end
            TOC_OFF_STATUS: begin
               s_d.prdata[3:0] = {s_q.match, s_q.out_state};
            end
            default: begin
               s_d.pslverr = 1'b1;   // unmapped address
            end
         endcase
      end
   end

   // ****************************************************************
   // state register
   // ****************************************************************
   // reset puts the compare values and output states to their defaults
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s_q           <= '0;
         s_q.cmp       <= {TOC_RST_CMP, TOC_RST_CMP};
         s_q.buf_      <= {TOC_RST_CMP, TOC_RST_CMP};
         s_q.out_state <= TOC_RST_OUT_STATE;
      end else begin
         s_q <= s_d;
      end
   end

   // ****************************************************************
   // outputs, all straight from the state register
   // ****************************************************************
   // every output is a flop; the pin path is one clock behind the port
   assign apb_pready_out  = s_q.pready;
   assign apb_pslverr_out = s_q.pslverr;
   assign apb_prdata_out  = s_q.prdata;
   assign pin_out         = s_q.pin;
   assign pin_oe_out      = s_q.pin_oe;
   assign irq_out         = s_q.irq;
   assign match_out       = s_q.match;
   assign top_value_a_out = s_q.cmp[TOC_CH_A];

endmodule : toc_unit

`default_nettype wire

// ---- inc/toc_pkg.sv ----
// package for the timer output compare block: offsets, layouts, state
package toc_pkg;

   // ****************************************************************
   // register byte offsets (apb, one aligned word each)
   // ****************************************************************
   localparam logic [7:0] TOC_OFF_CTRL_A   = 8'h00;
   localparam logic [7:0] TOC_OFF_CTRL_C   = 8'h04;
   localparam logic [7:0] TOC_OFF_FLAG     = 8'h08;
   localparam logic [7:0] TOC_OFF_MASK     = 8'h0c;
   localparam logic [7:0] TOC_OFF_CMP_A_LO = 8'h10;
   localparam logic [7:0] TOC_OFF_CMP_A_HI = 8'h14;
   localparam logic [7:0] TOC_OFF_CMP_B_LO = 8'h18;
   localparam logic [7:0] TOC_OFF_CMP_B_HI = 8'h1c;
   localparam logic [7:0] TOC_OFF_STATUS   = 8'h20;

   // ****************************************************************
   // field positions and reset values
   // ****************************************************************
   localparam int          TOC_POS_MODE     = 0;  // ctrl_a [3:0]
   localparam int          TOC_POS_ACT_B    = 4;  // ctrl_a [5:4]
   localparam int          TOC_POS_ACT_A    = 6;  // ctrl_a [7:6]
   localparam int          TOC_CH_A         = 1;  // bit 1 = channel a
   localparam int          TOC_CH_B         = 0;  // bit 0 = channel b
   localparam logic [1:0]  TOC_RST_OUT_STATE = 2'h0;
   localparam logic [15:0] TOC_RST_CMP      = 16'h0000;

   // waveform mode codes that matter here
   localparam logic [3:0] TOC_MODE_NORMAL   = 4'h0;
   localparam logic [3:0] TOC_MODE_CLR_A    = 4'h4;
   localparam logic [3:0] TOC_MODE_CLR_CAP  = 4'hc;
   localparam logic [3:0] TOC_MODE_RESERVED = 4'hd;

   // output action codes
   localparam logic [1:0] TOC_ACT_NONE   = 2'h0;
   localparam logic [1:0] TOC_ACT_TOGGLE = 2'h1;
   localparam logic [1:0] TOC_ACT_CLEAR  = 2'h2;
   localparam logic [1:0] TOC_ACT_SET    = 2'h3;

   // apb signals from the master
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } toc_apb_req_t;

   // timer core indications, same clock
   typedef struct packed {
      logic        tick;      // one-cycle timer clock enable
      logic        top;       // counter at top
      logic        bottom;    // counter at bottom
      logic        down;      // counter counting down
      logic        count_wr;  // cpu wrote the counter
      logic [15:0] count;     // timer_count
   } toc_timer_t;

   // whole state of the block
   typedef struct packed {
      logic [3:0]       mode;          // waveform_mode_sel
      logic [1:0][1:0]  act;           // compare_output_action per ch
      logic [1:0]       irq_en;        // compare_irq_enable
      logic [1:0]       flag;          // compare_match_flag
      logic [7:0]       temp;          // shared high-byte latch
      logic [1:0][15:0] cmp;           // active compare_value_reg
      logic [1:0][15:0] buf_;          // double buffer
      logic             block;         // matches blocked until tick
      logic [1:0]       pend;          // match seen at last tick
      logic [1:0]       match;         // raw equality, registered
      logic [1:0]       out_state;     // compare_output_state
      logic [1:0]       pin;
      logic [1:0]       pin_oe;
      logic [1:0]       irq;
      logic             pready;
      logic             pslverr;
      logic [31:0]      prdata;
   } toc_state_t;

endpackage : toc_pkg

// ---- test/test_timer_output_compare_units.sv ----
// self-checking bench for the output compare unit over apb
`timescale 1ns/100ps
`default_nettype none
module test_timer_output_compare_units;
   import toc_pkg::*;
   // ***************************************************
   // harness
   // ***************************************************
   logic         clk = 1'b0;
   logic         rst_n = 1'b0;
   toc_apb_req_t req = '0;
   toc_timer_t   tmr;
   logic         pready, pslverr, run = 1'b0, load = 1'b0;
   logic [31:0]  prdata, rdat;
   logic [15:0]  top_a, load_val = 16'h0000;
   logic [1:0]   ack = 2'b00, pdat = 2'b01, pdir = 2'b00;
   logic [1:0]   pin, oe, irq, match;
   logic         rerr;
   int           err_count = 0, n_tests = 0, cyc = 0, i;
   always #50 clk = ~clk;
   toc_unit dut (.core_clk_in(clk), .rst_n_in(rst_n), .apb_req_in(req),
      .apb_pready_out(pready), .apb_pslverr_out(pslverr),
      .apb_prdata_out(prdata), .timer_in(tmr), .irq_ack_in(ack),
      .port_data_in(pdat), .port_dir_in(pdir), .pin_out(pin),
      .pin_oe_out(oe), .irq_out(irq), .match_out(match),
      .top_value_a_out(top_a));
   toc_timer_model u_tmr (.core_clk_in(clk), .rst_n_in(rst_n),
      .run_in(run), .load_in(load), .load_val_in(load_val),
      .top_val_in(16'hffff), .timer_out(tmr));
   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : stop_test
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %0t seen %h want %h", $time, seen, exp);
      end
   endtask : chk
   // one apb transfer; request held until pready is sampled
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge clk);
      req.penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      req <= '0;
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(rdat, exp);
   endtask : rdc
   // cpu load of the counter, one-cycle strobe
   task automatic ld(input logic [15:0] v);
      @(posedge clk);
      load <= 1'b1;
      load_val <= v;
      @(posedge clk);
      load <= 1'b0;
   endtask : ld
   // hang guard, ceiling well above the expected run
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         stop_test;
      end
   end
   // ***************************************************
   // scenarios
   // ***************************************************
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      rdc(TOC_OFF_CTRL_A, 32'h0);
      rdc(TOC_OFF_STATUS, 32'hc);
      chk({30'h0, match}, 32'h3);
      rdc(TOC_OFF_CMP_A_LO, 32'h0);
      bus(1'b0, 8'h24, 32'h0);
      chk({31'h0, rerr}, 32'h1);
      wr(TOC_OFF_CMP_A_HI, 32'h01);
      wr(TOC_OFF_CMP_A_LO, 32'h23);
      @(posedge clk);
      chk({16'h0, top_a}, 32'h0123);
      rdc(TOC_OFF_CMP_A_HI, 32'h01);
      rdc(TOC_OFF_CMP_A_LO, 32'h23);
      wr(TOC_OFF_CMP_B_HI, 32'h00);
      wr(TOC_OFF_CMP_B_LO, 32'h40);
      wr(TOC_OFF_MASK, 32'h2);
      run <= 1'b1;
      repeat (3000) begin
         @(posedge clk);
         if (irq[TOC_CH_A] === 1'b1) break;
      end
      chk({30'h0, irq}, 32'h2);
      rdc(TOC_OFF_FLAG, 32'h3);
      wr(TOC_OFF_FLAG, 32'h1);
      rdc(TOC_OFF_FLAG, 32'h2);
      wr(TOC_OFF_MASK, 32'h3);
      // stop ticks so the service pulse meets no new hit
      run <= 1'b0;
      @(posedge clk);
      ack <= 2'b10;
      @(posedge clk);
      ack <= 2'b00;
      rdc(TOC_OFF_FLAG, 32'h0);
      chk({30'h0, irq}, 32'h0);
      // a load equal to the compare value loses that match
      wr(TOC_OFF_CMP_A_HI, 32'h00);
      wr(TOC_OFF_CMP_A_LO, 32'h40);
      ld(16'h0040);
      run <= 1'b1;
      repeat (20) @(posedge clk);
      rdc(TOC_OFF_FLAG, 32'h0);
      run <= 1'b0;
      ld(16'h003c);
      run <= 1'b1;
      repeat (20) @(posedge clk);
      rdc(TOC_OFF_FLAG, 32'h3);
      run <= 1'b0;
      wr(TOC_OFF_FLAG, 32'h3);
      rdc(TOC_OFF_STATUS, 32'h0);
      wr(TOC_OFF_CTRL_A, 32'h40);
      wr(TOC_OFF_CTRL_C, 32'h2);
      pdir <= 2'b11;
      rdc(TOC_OFF_STATUS, 32'h2);
      chk({30'h0, pin}, 32'h3);
      chk({30'h0, oe}, 32'h3);
      rdc(TOC_OFF_FLAG, 32'h0);
      // toggle, clear, set from state one
      for (i = 1; i < 4; i++) begin
         wr(TOC_OFF_CTRL_A, i << 6);
         wr(TOC_OFF_CTRL_C, 32'h2);
         rdc(TOC_OFF_STATUS, (i == 3) ? 32'h2 : 32'h0);
      end
      wr(TOC_OFF_CTRL_A, 32'hc4);
      rdc(TOC_OFF_STATUS, 32'h2);
      wr(TOC_OFF_CTRL_A, 32'h4f);
      wr(TOC_OFF_CTRL_C, 32'h2);
      rdc(TOC_OFF_STATUS, 32'h2);
      // buffered write waits for bottom
      wr(TOC_OFF_CMP_A_HI, 32'h00);
      wr(TOC_OFF_CMP_A_LO, 32'h80);
      @(posedge clk);
      chk({16'h0, top_a}, 32'h0040);
      rdc(TOC_OFF_CMP_A_LO, 32'h80);
      ld(16'h0000);
      run <= 1'b1;
      repeat (6) @(posedge clk);
      chk({16'h0, top_a}, 32'h0080);
      stop_test;
   end
endmodule : test_timer_output_compare_units
`default_nettype wire

// ---- test/toc_timer_model.sv ----
// behavioural timer core feeding count, tick and extremes to the unit
`timescale 1ns/100ps
`default_nettype none
module toc_timer_model (
   input  wire logic          core_clk_in,
   input  wire logic          rst_n_in,
   input  wire logic          run_in,
   input  wire logic          load_in,
   input  wire logic [15:0]   load_val_in,
   input  wire logic [15:0]   top_val_in,
   output toc_pkg::toc_timer_t timer_out
);
   import toc_pkg::*;
   // ***************************************************
   // counter
   // ***************************************************
   logic [15:0] cnt_q;
   logic        tick_q;
   logic        wr_q;
   // tick every second clock; a cpu load wins over counting
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt_q  <= 16'h0000;
         tick_q <= 1'b0;
         wr_q   <= 1'b0;
      end else begin
         tick_q <= run_in & ~tick_q;
         wr_q   <= load_in;
         if (load_in) begin
            cnt_q <= load_val_in;
         end else if (tick_q) begin
            cnt_q <= (cnt_q == top_val_in) ? 16'h0000 : cnt_q + 16'h0001;
         end
      end
   end
   // extremes follow the count; up counting only
   assign timer_out = '{tick: tick_q, top: cnt_q == top_val_in,
      bottom: cnt_q == 16'h0000, down: 1'b0, count_wr: wr_q, count: cnt_q};
endmodule : toc_timer_model
`default_nettype wire

// ---- test/toc_unit_properties.sv ----
// concurrent checks on the ports of the output compare unit
`timescale 1ns/100ps
`default_nettype none
module toc_unit_properties (
   input wire logic                  core_clk_in,
   input wire logic                  rst_n_in,
   input wire toc_pkg::toc_apb_req_t apb_req_in,
   input wire logic                  apb_pready_out,
   input wire logic                  apb_pslverr_out,
   input wire logic [31:0]           apb_prdata_out,
   input wire toc_pkg::toc_timer_t   timer_in,
   input wire logic [1:0]            irq_ack_in,
   input wire logic [1:0]            port_dir_in,
   input wire logic [1:0]            pin_oe_out,
   input wire logic [1:0]            irq_out,
   input wire logic [1:0]            match_out,
   input wire logic [15:0]           top_value_a_out
);
   import toc_pkg::*;
   // ***************************************************
   // bus, compare and pin relations
   // ***************************************************
   logic acc;
   // access phase seen by the slave
   assign acc = apb_req_in.psel & apb_req_in.penable;
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!rst_n_in);
   chk_ready_pulse: assert property (apb_pready_out |=> !apb_pready_out)
      else $error("pready stood longer than one cycle");
   chk_ready_timing: assert property ((acc && !$past(acc))
      |=> apb_pready_out)
      else $error("pready late after access start");
   chk_ready_cause: assert property (apb_pready_out |-> $past(acc))
      else $error("pready without an access");
   chk_err_ready: assert property (apb_pslverr_out |-> apb_pready_out)
      else $error("pslverr outside a completion");
   chk_rdata_idle: assert property (!apb_pready_out
      |-> apb_prdata_out == 32'h0)
      else $error("read data outside a completion");
   chk_dir_copy: assert property ($past(rst_n_in)
      |-> pin_oe_out == $past(port_dir_in))
      else $error("pin direction not taken from port");
   // cached top equal across two edges means the active value is steady
   chk_match_a: assert property ((timer_in.count == top_value_a_out)
      ##1 $stable(top_value_a_out) |-> match_out[TOC_CH_A])
      else $error("equality without match on channel a");
   chk_top_write: assert property ($changed(top_value_a_out) |->
      $past(apb_pready_out && apb_req_in.pwrite)
      || $past(timer_in.tick))
      else $error("compare value changed without cause");
   // ack with no new tick pending must drop the request
   chk_ack_clear: assert property (irq_ack_in[TOC_CH_A]
      && !timer_in.tick |-> ##[1:2] !irq_out[TOC_CH_A])
      else $error("interrupt stayed after service");
   cov_irq_a: cover property ($rose(irq_out[TOC_CH_A]));
   cov_slverr: cover property (apb_pslverr_out);
   cov_match_b: cover property ($rose(match_out[TOC_CH_B]));
endmodule : toc_unit_properties
bind toc_unit toc_unit_properties u_chk (.core_clk_in, .rst_n_in,
   .apb_req_in, .apb_pready_out, .apb_pslverr_out, .apb_prdata_out,
   .timer_in, .irq_ack_in, .port_dir_in, .pin_oe_out, .irq_out,
   .match_out, .top_value_a_out);
`default_nettype wire
